/* src/scan_seq.sv */
// Scan-layer trigger sequencer top level.
// Overview of operation
// - Interval timer programmable 0 to 99999.999 s in 1 ms steps.
// - Timer pacing starts the next scan when the interval expires.
// - A short interval waits until the running scan has finished.
// - Step key also paces in timer, external, bus and trigger-bus modes.
// - In those modes step after a scan starts another only if count permits.
// - External pacing: external trigger pulse enters the channel layer.
// - Bus pacing: a bus trigger enters the channel layer.
// - Manual pacing: only the step key enters the channel layer.
// - A six-line trigger bus carries pulses in and out.
// - Trigger-bus pacing: a pulse on the chosen input line enters.
// - Input and output lines are 1 to 6; same line for both is rejected.
// - Immediate pacing enters the channel layer without waiting.
// - Hold stalls pacing until another selection is made.
// - Scan count 1 to 9999 runs exactly that many; infinite repeats.
// - A stored count of zero reads and acts as infinite.
// - Source bypass skips the first event for external or trigger bus.
// - Acceptor setting disables bypass; every pass waits for the event.
// - Each channel event opens the closed channel and closes the next.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module scan_seq (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Trigger sources.
    input wire logic ext_trig_i,
    input wire logic bus_trig_i,
    input wire logic step_key_i,
    input wire logic [5:0] trig_line_i,
    // Trigger bus output lines, open drain.
    output logic [5:0] trig_line_o,
    output logic [5:0] trig_line_oe_o,
    // Channel layer.
    output logic scan_start_o,
    input wire logic scan_done_i,
    output logic busy_o
);
    logic [2:0] src_q;
    logic bypass_q;
    logic [26:0] interval_q;
    logic [13:0] count_q;
    logic [13:0] remain_q;
    logic [2:0] line_in_q;
    logic [2:0] line_out_q;
    logic line_err_q;
    logic first_q;
    logic scan_q;
    logic armed_q;
    logic [5:0] oe_q;
    logic [1:0] pulse_cnt_q;
    scan_seq_pkg::state_type state_q;
    logic [5:0] line_rise;
    logic [2:0] pin_rise;
    logic expired;
    logic event_hit;
    logic go;
    logic more;
    logic ctrl_wr;
    logic arm_cmd;
    logic abort_cmd;
    logic [2:0] new_in;
    logic [2:0] new_out;
    logic arm_ok;
    logic timer_wr;
    logic count_wr;
    logic lines_wr;

    function automatic logic line_ok(input logic [2:0] l);
        line_ok = (l >= scan_seq_pkg::LINE_MIN) && (l <= scan_seq_pkg::LINE_MAX);
    endfunction

    // One-hot mask of a trigger-bus line numbered from one.
    function automatic logic [5:0] line_bit(input logic [2:0] l);
        line_bit = 6'h01 << (l - 3'h1);
    endfunction

    pin_sync #(.W(3)) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .pin_i({step_key_i, bus_trig_i, ext_trig_i}),
        .rise_o(pin_rise)
    );

    pin_sync #(.W(scan_seq_pkg::TRIG_LINES)) u_line_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .pin_i(trig_line_i),
        .rise_o(line_rise)
    );

    ms_timer u_timer (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .restart_i(go),
        .interval_i(interval_q),
        .expired_o(expired)
    );

    assign ctrl_wr = wr_i && (addr_i == scan_seq_pkg::ADDR_CTRL);
    assign arm_cmd = wr_i && (addr_i == scan_seq_pkg::ADDR_CMD)
        && wdata_i[scan_seq_pkg::CMD_ARM_BIT];
    assign abort_cmd = wr_i && (addr_i == scan_seq_pkg::ADDR_CMD)
        && wdata_i[scan_seq_pkg::CMD_ABORT_BIT];
    assign new_in = wdata_i[scan_seq_pkg::LINE_IN_LSB +: 3];
    assign new_out = wdata_i[scan_seq_pkg::LINE_OUT_LSB +: 3];
    assign timer_wr = wr_i && (addr_i == scan_seq_pkg::ADDR_TIMER);
    assign count_wr = wr_i && (addr_i == scan_seq_pkg::ADDR_COUNT);
    assign lines_wr = wr_i && (addr_i == scan_seq_pkg::ADDR_LINES);
    // Arm is honoured from idle only, so a repeated arm cannot reload a running count.
    assign arm_ok = arm_cmd && (state_q == scan_seq_pkg::ST_IDLE);

    // Configuration registers.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            src_q <= scan_seq_pkg::SRC_IMMEDIATE;
            bypass_q <= 1'b0;
        end else if (ctrl_wr) begin
            src_q <= wdata_i[scan_seq_pkg::CTRL_SRC_LSB +: 3];
            bypass_q <= wdata_i[scan_seq_pkg::CTRL_BYPASS_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            interval_q <= scan_seq_pkg::TIMER_RST_MS;
        end else if (timer_wr) begin
            // Values beyond the range are clamped rather than wrapped.
            if (wdata_i[26:0] > scan_seq_pkg::TIMER_MAX_MS || wdata_i[31:27] != 5'h00) begin
                interval_q <= scan_seq_pkg::TIMER_MAX_MS;
            end else begin
                interval_q <= wdata_i[26:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            count_q <= scan_seq_pkg::COUNT_RST;
        end else if (count_wr) begin
            if (wdata_i[13:0] > scan_seq_pkg::COUNT_MAX || wdata_i[31:14] != 18'h00000) begin
                count_q <= scan_seq_pkg::COUNT_MAX;
            end else begin
                count_q <= wdata_i[13:0];
            end
        end
    end

    // A rejected setting keeps the previous lines and flags an error.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            line_in_q <= scan_seq_pkg::LINE_IN_RST;
            line_out_q <= scan_seq_pkg::LINE_OUT_RST;
            line_err_q <= 1'b0;
        end else if (lines_wr) begin
            if (line_ok(new_in) && line_ok(new_out) && new_in != new_out) begin
                line_in_q <= new_in;
                line_out_q <= new_out;
                line_err_q <= 1'b0;
            end else begin
                line_err_q <= 1'b1;
            end
        end
    end

    // Pacing event decode.
    always_comb begin
        case (src_q)
            scan_seq_pkg::SRC_TIMER: event_hit = expired && !scan_q;
            scan_seq_pkg::SRC_EXTERNAL: event_hit = pin_rise[0];
            scan_seq_pkg::SRC_BUS: event_hit = pin_rise[1];
            scan_seq_pkg::SRC_MANUAL: event_hit = pin_rise[2];
            scan_seq_pkg::SRC_TRIGBUS: event_hit = |(line_rise & line_bit(line_in_q));
            scan_seq_pkg::SRC_IMMEDIATE: event_hit = 1'b1;
            scan_seq_pkg::SRC_HOLD: event_hit = 1'b0;
            default: event_hit = 1'b0;
        endcase
        // The step key adds to every triggered mode except hold and immediate.
        if (src_q == scan_seq_pkg::SRC_TIMER || src_q == scan_seq_pkg::SRC_EXTERNAL
            || src_q == scan_seq_pkg::SRC_BUS || src_q == scan_seq_pkg::SRC_TRIGBUS) begin
            event_hit = event_hit || pin_rise[2];
        end
    end

    // Remaining count permits another scan.
    assign more = (count_q == scan_seq_pkg::COUNT_INFINITE) || (remain_q != 14'h0000);

    // A scan starts only while waiting and never while one is in flight.
    assign go = (state_q == scan_seq_pkg::ST_WAIT) && more && !abort_cmd
        && (event_hit || (first_q && bypass_q
        && (src_q == scan_seq_pkg::SRC_EXTERNAL
        || src_q == scan_seq_pkg::SRC_TRIGBUS)));

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_q <= scan_seq_pkg::ST_IDLE;
        end else if (abort_cmd) begin
            state_q <= scan_seq_pkg::ST_IDLE;
        end else begin
            case (state_q)
                scan_seq_pkg::ST_IDLE: begin
                    if (arm_cmd) begin
                        state_q <= scan_seq_pkg::ST_WAIT;
                    end
                end
                scan_seq_pkg::ST_WAIT: begin
                    if (go) begin
                        state_q <= scan_seq_pkg::ST_SCAN;
                    end else if (!more) begin
                        state_q <= scan_seq_pkg::ST_IDLE;
                    end
                end
                scan_seq_pkg::ST_SCAN: begin
                    if (scan_done_i) begin
                        state_q <= scan_seq_pkg::ST_WAIT;
                    end
                end
                default: state_q <= scan_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // Bypass covers the first pass only; every new arm opens a fresh first pass.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            first_q <= 1'b0;
        end else if (arm_ok) begin
            first_q <= 1'b1;
        end else if (go) begin
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            remain_q <= '0;
        end else if (arm_ok) begin
            remain_q <= count_q;
        end else if (scan_done_i && state_q == scan_seq_pkg::ST_SCAN
            && remain_q != 14'h0000) begin
            remain_q <= remain_q - 14'h0001;
        end
    end

    assign scan_q = (state_q == scan_seq_pkg::ST_SCAN);

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            armed_q <= 1'b0;
            scan_start_o <= 1'b0;
        end else begin
            armed_q <= (state_q != scan_seq_pkg::ST_IDLE);
            scan_start_o <= go;
        end
    end

    // Output trigger pulse on the chosen line at each scan start; held four cycles
    // so that slow receivers see it. The mask is latched at the start, so the pin
    // stays glitch free and a line change cannot cut a pulse short.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pulse_cnt_q <= 2'h0;
            oe_q <= 6'h00;
        end else if (go) begin
            pulse_cnt_q <= 2'h3;
            oe_q <= line_bit(line_out_q);
        end else if (pulse_cnt_q != 2'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 2'h1;
        end else begin
            oe_q <= 6'h00;
        end
    end

    assign trig_line_o = 6'h00;
    assign trig_line_oe_o = oe_q;
    assign busy_o = armed_q;

    // Register read, one cycle later.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                scan_seq_pkg::ADDR_CTRL: rdata_o <= {28'h0000000, bypass_q, src_q};
                scan_seq_pkg::ADDR_TIMER: rdata_o <= {5'h00, interval_q};
                scan_seq_pkg::ADDR_COUNT: rdata_o <= {18'h00000, count_q};
                scan_seq_pkg::ADDR_LINES: rdata_o <= {25'h0000000, line_out_q, 1'b0, line_in_q};
                scan_seq_pkg::ADDR_STATUS: rdata_o <= {27'h0000000, line_err_q, first_q,
                    expired, state_q};
                scan_seq_pkg::ADDR_REMAIN: rdata_o <= {18'h00000, remain_q};
                default: rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end
endmodule

/* pkg/scan_seq_pkg.sv */
// Constants, register map and types of the scan-layer trigger sequencer.
package scan_seq_pkg;
    // Register indices; byte address is the index itself on this plain port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TIMER = 4'h1;
    localparam logic [3:0] ADDR_COUNT = 4'h2;
    localparam logic [3:0] ADDR_LINES = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_REMAIN = 4'h5;
    localparam logic [3:0] ADDR_CMD = 4'h6;
    // Control register fields.
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_BYPASS_BIT = 3;
    localparam int CMD_ARM_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;
    // Lines register fields: input line in [2:0], output line in [6:4].
    localparam int LINE_IN_LSB = 0;
    localparam int LINE_OUT_LSB = 4;
    localparam logic [2:0] LINE_MIN = 3'h1;
    localparam logic [2:0] LINE_MAX = 3'h6;
    localparam logic [2:0] LINE_IN_RST = 3'h1;
    localparam logic [2:0] LINE_OUT_RST = 3'h2;
    localparam int TRIG_LINES = 6;
    // Timer interval in milliseconds.
    localparam logic [26:0] TIMER_MAX_MS = 27'h5f5e0ff;
    localparam logic [26:0] TIMER_RST_MS = 27'h0000001;
    // Scan count.
    localparam logic [13:0] COUNT_MAX = 14'h270f;
    localparam logic [13:0] COUNT_RST = 14'h0001;
    localparam logic [13:0] COUNT_INFINITE = 14'h0000;
    // Tick timing.
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [2:0] {
        SRC_IMMEDIATE = 3'b000,
        SRC_TIMER = 3'b001,
        SRC_EXTERNAL = 3'b010,
        SRC_BUS = 3'b011,
        SRC_MANUAL = 3'b100,
        SRC_TRIGBUS = 3'b101,
        SRC_HOLD = 3'b110
    } source_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SCAN = 2'b10
    } state_type;
endpackage

/* src/pin_sync.sv */
// Two-stage synchroniser with rising-edge pulse for trigger inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Raw pins and synchronised edges.
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~last_q;
endmodule

/* src/ms_timer.sv */
// Millisecond tick and scan interval timer.
`timescale 1ns/1ps
module ms_timer #(
    parameter int TICK_CYCLES = scan_seq_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Control.
    input wire logic restart_i,
    input wire logic [26:0] interval_i,
    // Status.
    output logic expired_o
);
    logic [17:0] div_q;
    logic [26:0] ms_q;
    logic tick;

    assign tick = (div_q == 18'(TICK_CYCLES - 1));

    // The divider restarts with the interval so the first millisecond is whole.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || restart_i || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 18'h00001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ms_q <= '0;
        end else if (restart_i) begin
            ms_q <= '0;
        end else if (tick && !expired_o) begin
            ms_q <= ms_q + 27'h0000001;
        end
    end

    // Expiry is a level held until the next restart.
    assign expired_o = (ms_q >= interval_i);
endmodule

/* test/scan_seq_props.sv */
// Port assertions and covers of the scan sequencer.
`timescale 1ns/1ps
module scan_seq_props (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Trigger pins.
    input wire logic ext_trig_i,
    input wire logic bus_trig_i,
    input wire logic step_key_i,
    input wire logic [5:0] trig_line_i,
    input wire logic [5:0] trig_line_o,
    input wire logic [5:0] trig_line_oe_o,
    // Channel layer.
    input wire logic scan_start_o,
    input wire logic scan_done_i,
    input wire logic busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic scan_q;
    // An abort leaves no completion behind, so leaving the armed state also closes the scan.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !busy_o || scan_done_i) begin
            scan_q <= 1'b0;
        end else if (scan_start_o) begin
            scan_q <= 1'b1;
        end
    end
    a_start_pulse: assert property (scan_start_o |=> !scan_start_o)
        else $error("scan start longer than one cycle");
    a_start_armed: assert property (scan_start_o |-> busy_o)
        else $error("scan start while not armed");
    a_one_scan: assert property (scan_start_o |-> !scan_q)
        else $error("scan start before previous scan completed");
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data without a read");
    a_line_low: assert property (trig_line_o == 6'h00)
        else $error("trigger line driven high");
    a_oe_single: assert property ($onehot0(trig_line_oe_o))
        else $error("more than one output line pulled");
    a_oe_width: assert property ($rose(|trig_line_oe_o) |->
        (|trig_line_oe_o) [*4] ##1 !(|trig_line_oe_o))
        else $error("output line pulse not four cycles");
    a_oe_cause: assert property ($rose(|trig_line_oe_o) |->
        scan_start_o || $past(scan_start_o) || $past(scan_start_o, 2))
        else $error("output line pulse without scan start");
    c_start: cover property (scan_start_o);
    c_oe: cover property ($rose(|trig_line_oe_o));
    c_idle: cover property ($fell(busy_o));
endmodule

/* test/channel_model.sv */
// Channel-layer model answering each scan start with a completion pulse.
`timescale 1ns/1ps
module channel_model #(
    parameter int DELAY = 8
) (
    // Clock.
    input wire logic mclk_i,
    // Handshake with the sequencer.
    input wire logic start_i,
    output logic done_o
);
    int cnt = 0;
    initial done_o = 1'b0;
    // Each start walks the channels; completion follows the last one.
    always @(posedge mclk_i) begin
        done_o <= 1'b0;
        if (start_i === 1'b1) begin
            cnt <= DELAY;
        end else if (cnt == 1) begin
            done_o <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* test/testbench.sv */
// Self-checking bench of the scan sequencer.
`timescale 1ns/1ps
module testbench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [8:0] pins = 9'h000;
    logic [31:0] rdata_o;
    logic [5:0] trig_line_o;
    logic [5:0] trig_line_oe_o;
    logic [5:0] oe_seen = 6'h00;
    logic scan_start_o;
    logic scan_done_i;
    logic busy_o;
    logic [31:0] d;
    logic [3:0] ctl_t [6] = '{4'h3, 4'h4, 4'h5, 4'h2, 4'h3, 4'h5};
    logic [8:0] bad_t [6] = '{9'h001, 9'h023, 9'h011, 9'h002, 9'h001, 9'h010};
    logic [8:0] good_t [6] = '{9'h002, 9'h004, 9'h020, 9'h004, 9'h004, 9'h004};
    int n_fail = 0;
    int total_checks = 0;
    int n_starts = 0;
    int cycles = 0;

    scan_seq dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_trig_i(pins[0]),
        .bus_trig_i(pins[1]), .step_key_i(pins[2]), .trig_line_i(pins[8:3]),
        .trig_line_o(trig_line_o), .trig_line_oe_o(trig_line_oe_o),
        .scan_start_o(scan_start_o), .scan_done_i(scan_done_i), .busy_o(busy_o));
    channel_model #(.DELAY(8)) chan (.mclk_i(mclk_i), .start_i(scan_start_o),
        .done_o(scan_done_i));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        oe_seen = oe_seen | trig_line_oe_o;
        if (scan_start_o === 1'b1) begin
            n_starts = n_starts + 1;
        end
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            results();
        end
    end

    task automatic results();
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic go(input logic [3:0] ctl, input logic [31:0] cnt);
        wr(scan_seq_pkg::ADDR_COUNT, cnt);
        wr(scan_seq_pkg::ADDR_CTRL, {28'h0, ctl});
        n_starts = 0;
        oe_seen = 6'h00;
        wr(scan_seq_pkg::ADDR_CMD, 32'h1);
    endtask

    task automatic pulse(input logic [8:0] m);
        @(posedge mclk_i);
        pins <= m;
        pause(4);
        pins <= 9'h000;
        pause(40);
    endtask

    initial begin
        pause(12);
        rst_b_i <= 1'b1;
        rd(scan_seq_pkg::ADDR_COUNT);
        chk("count reset", d, 32'h1);
        rd(scan_seq_pkg::ADDR_TIMER);
        chk("timer reset", d, 32'h1);
        rd(4'hf);
        chk("unmapped read", d, 32'h0);
        wr(scan_seq_pkg::ADDR_TIMER, 32'h7ffffff);
        rd(scan_seq_pkg::ADDR_TIMER);
        chk("timer clamp", d, 32'h5f5e0ff);
        wr(scan_seq_pkg::ADDR_COUNT, 32'h2710);
        rd(scan_seq_pkg::ADDR_COUNT);
        chk("count clamp", d, 32'h270f);
        wr(scan_seq_pkg::ADDR_COUNT, 32'h0);
        rd(scan_seq_pkg::ADDR_COUNT);
        chk("count zero", d, 32'h0);
        wr(scan_seq_pkg::ADDR_LINES, 32'h33);
        wr(scan_seq_pkg::ADDR_LINES, 32'h07);
        rd(scan_seq_pkg::ADDR_LINES);
        chk("bad lines", d, 32'h21);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("line error", d[4], 32'h1);
        wr(scan_seq_pkg::ADDR_LINES, 32'h53);
        rd(scan_seq_pkg::ADDR_LINES);
        chk("good lines", d, 32'h53);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("line error clear", d[4], 32'h0);
        go(4'h0, 32'h3);
        pause(80);
        chk("immediate scans", n_starts, 32'h3);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("idle after count", d[1:0], 32'h0);
        go(4'h0, 32'h0);
        pause(120);
        chk("infinite busy", busy_o, 32'h1);
        chk("infinite runs", n_starts > 5, 32'h1);
        rd(scan_seq_pkg::ADDR_REMAIN);
        chk("infinite remain", d, 32'h0);
        wr(scan_seq_pkg::ADDR_CMD, 32'h2);
        pause(20);
        go(4'h6, 32'h1);
        pulse(9'h007);
        chk("hold stall", n_starts, 32'h0);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("hold waits", d[1:0], 32'h1);
        wr(scan_seq_pkg::ADDR_CTRL, 32'h0);
        pause(30);
        chk("hold release", n_starts, 32'h1);
        go(4'h2, 32'h2);
        pause(30);
        chk("acceptor waits", n_starts, 32'h0);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("first pass pending", d[3], 32'h1);
        pulse(9'h001);
        rd(scan_seq_pkg::ADDR_REMAIN);
        chk("remain after one", d, 32'h1);
        pulse(9'h001);
        chk("external scans", n_starts, 32'h2);
        pulse(9'h004);
        chk("step after last", n_starts, 32'h2);
        for (int i = 0; i < 6; i++) begin
            go(ctl_t[i], 32'h1);
            pulse(bad_t[i]);
            chk($sformatf("other event %0d", i), n_starts, 32'h0);
            pulse(good_t[i]);
            chk($sformatf("pacing event %0d", i), n_starts, 32'h1);
        end
        chk("output line", oe_seen, 32'h10);
        go(4'ha, 32'h2);
        pause(60);
        chk("bypass first", n_starts, 32'h1);
        rd(scan_seq_pkg::ADDR_STATUS);
        chk("first pass used", d[3], 32'h0);
        pulse(9'h001);
        chk("bypass then event", n_starts, 32'h2);
        wr(scan_seq_pkg::ADDR_TIMER, 32'h0);
        go(4'h1, 32'h3);
        pause(80);
        chk("timer scans", n_starts, 32'h3);
        pulse(9'h004);
        chk("timer step done", n_starts, 32'h3);
        results();
    end
endmodule

bind scan_seq scan_seq_props props (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_trig_i(ext_trig_i),
    .bus_trig_i(bus_trig_i), .step_key_i(step_key_i), .trig_line_i(trig_line_i),
    .trig_line_o(trig_line_o), .trig_line_oe_o(trig_line_oe_o), .scan_start_o(scan_start_o),
    .scan_done_i(scan_done_i), .busy_o(busy_o));
